// *** inc/pos_loop_pkg.sv ***
// Package: widths, timing constants and carrier structs of the position loop block
package pos_loop_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int POS_W  = 32;
    localparam int GAIN_W = 16;
    localparam int TIM_W  = 16;
    localparam int DT_MAX = 8;     // Depth of the pre-control dead-time line
    localparam int DT_W   = 3;
    localparam int FRAC_W = 8;     // Gains are Q8.8
    localparam int LAG_W  = 4;     // Lag filters as shift of 2^k

    // ****************************************************************
    // Encoder control word layout
    // ****************************************************************
    localparam int ECW_REF_BIT   = 0;
    localparam int ECW_PROBE_BIT = 1;
    localparam int ECW_SEL_BIT   = 2;
    localparam int ECW_EDGE_BIT  = 3;
    localparam int ECW_ABORT_BIT = 4;
    localparam int ECW_W         = 5;

    localparam logic [TIM_W-1:0] TIM_RESET = 16'h0000;
    localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [GAIN_W-1:0] prop_gain;
        logic [GAIN_W-1:0] integral_gain;
        logic [POS_W-1:0]  speed_limit_out;
        logic [LAG_W-1:0]  setpoint_filter_tc;
        logic [GAIN_W-1:0] precontrol_factor;
        logic [DT_W-1:0]   precontrol_deadtime;
        logic [LAG_W-1:0]  precontrol_lag;
    } loop_cfg_t;

    typedef struct packed {
        logic [POS_W-1:0] standstill_window;
        logic [TIM_W-1:0] standstill_time;
        logic [POS_W-1:0] positioning_window;
        logic [TIM_W-1:0] positioning_time;
        logic [POS_W-1:0] follow_err_tolerance;
        logic [POS_W-1:0] cam_pos_one;
        logic [POS_W-1:0] cam_pos_two;
    } mon_cfg_t;

    typedef struct packed {
        logic             func_active;   // Encoder reports function running
        logic             meas_present;  // Encoder delivered a captured position
        logic             fault;
        logic [POS_W-1:0] meas_value;
    } enc_status_t;

    typedef enum logic [1:0] {
        FN_IDLE  = 2'b00,
        FN_RUN   = 2'b01,
        FN_DONE  = 2'b10,
        FN_BLOCK = 2'b11
    } fn_state_t;

endpackage

// *** design/position_loop_monitor_probe.sv ***
// Position loop with monitors, cam outputs and probe / reference-mark handshake
// Contract
// - PI loop, proportional gain times adaptation input
// - Loop runs only when both enables high
// - Clamp loop speed output without pre-control
// - Setpoint lag; pre-control dead time then lag
// - Pre-control factor scales; zero removes it
// - Standstill timer expiry outside window faults
// - Positioning window checked once at expiry
// - Zero window disables its monitor
// - Following error over tolerance faults, clears ok
// - Cam output high while position at/below cam
// - Rising request edge starts via control word
// - Active and valid bits follow encoder
// - Results held until request drops
// - Early request drop aborts, clears active
// - Both requests: abort, alarm until released
// - Encoder fault during function raises alarm
// - Probe select and edge go to encoder
// - Direct probe pins bypass the encoder word
// - Message when probe input already used
// - Tracking: monitors off, setpoint follows actual
`timescale 1ns/1ps
module position_loop_monitor_probe
    import pos_loop_pkg::*;
(
    input  wire logic              clk,                   // 40 MHz clock
    input  wire logic              reset,                 // Sync reset, active high
    input  wire logic              cycle_en,              // Position-controller cycle pulse
    input  wire loop_cfg_t         loop_cfg,              // Loop configuration
    input  wire mon_cfg_t          mon_cfg,               // Monitor configuration
    input  wire logic [POS_W-1:0]  position_setpoint,     // Position setpoint
    input  wire logic [POS_W-1:0]  actual_position,       // Actual position
    input  wire logic [POS_W-1:0]  speed_precontrol_in,   // Speed pre-control source
    input  wire logic [GAIN_W-1:0] gain_adapt_in,         // Gain adaptation, Q8.8
    input  wire logic [POS_W-1:0]  speed_limit_in,        // Speed limit source
    input  wire logic              loop_enable_a,         // Loop enable one
    input  wire logic              loop_enable_b,         // Loop enable two
    input  wire logic              tracking_mode_sel,     // Tracking mode select
    input  wire logic              setpoint_stationary,   // Setpoint stationary
    input  wire logic              travel_cmd_active,     // Travel command active
    input  wire logic              ref_search_req,        // Reference search request
    input  wire logic              probe_meas_req,        // Probe measurement request
    input  wire logic              probe_select,          // Probe 1 (0) or 2 (1)
    input  wire logic              probe_edge_select,     // Rising (0) or falling (1)
    input  wire logic              direct_probe_one_pin,  // Direct probe 1 terminal
    input  wire logic              direct_probe_two_pin,  // Direct probe 2 terminal
    input  wire logic              direct_probe_one_en,   // Use direct terminal for probe 1
    input  wire logic              direct_probe_two_en,   // Use direct terminal for probe 2
    input  wire logic              probe_one_in_use,      // Probe 1 claimed elsewhere
    input  wire logic              probe_two_in_use,      // Probe 2 claimed elsewhere
    input  wire enc_status_t       enc_status,            // Encoder status word
    output logic [POS_W-1:0]       speed_setpoint,        // Speed setpoint out
    output logic [POS_W-1:0]       speed_limit_out,       // Configured limit out
    output logic [POS_W-1:0]       follow_err_value,      // Latest following error
    output logic                   follow_ok_bit,         // Following error in tolerance
    output logic                   standstill_fault,      // Standstill fault
    output logic                   positioning_fault,     // Positioning fault
    output logic                   follow_err_fault,      // Following-error fault
    output logic                   cam_out_one,           // Position <= cam 1
    output logic                   cam_out_two,           // Position <= cam 2
    output logic [ECW_W-1:0]       enc_ctrl_word,         // Encoder control word
    output logic                   func_active_bit,       // Function active
    output logic                   meas_valid_bit,        // Measurement valid
    output logic [POS_W-1:0]       captured_position,     // Captured position
    output logic                   func_interrupted,      // Function-interrupted alarm
    output logic                   probe_conflict_msg     // Probe input already in use
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [POS_W-1:0] abs_val(input logic [POS_W-1:0] v);
        abs_val = v[POS_W-1] ? (~v + 32'h0000_0001) : v;
    endfunction

    // Q8.8 scaling; keeps the low word of the shifted product
    function automatic logic [POS_W-1:0] scale(input logic [POS_W-1:0] v,
                                               input logic [GAIN_W-1:0] g);
        logic signed [POS_W+GAIN_W:0] p;
        p = $signed(v) * $signed({1'b0, g});
        scale = POS_W'(p >>> FRAC_W);
    endfunction

    function automatic logic [POS_W-1:0] lag(input logic [POS_W-1:0] y,
                                             input logic [POS_W-1:0] x,
                                             input logic [LAG_W-1:0] k);
        lag = y + POS_W'($signed(x - y) >>> k);
    endfunction

    function automatic logic [POS_W-1:0] clamp(input logic [POS_W-1:0] v,
                                               input logic [POS_W-1:0] lim);
        logic [POS_W-1:0] al;
        al = abs_val(lim);
        if ($signed(v) > $signed(al)) begin
            clamp = al;
        end else if ($signed(v) < -$signed(al)) begin
            clamp = ~al + 32'h0000_0001;
        end else begin
            clamp = v;
        end
    endfunction

    // ****************************************************************
    // Input synchronisers for the direct probe terminals
    // ****************************************************************
    logic [1:0] dp_meta_q;
    logic [1:0] dp_sync_q;
    logic [1:0] dp_prev_q;

    always_ff @(posedge clk) begin
        dp_meta_q <= {direct_probe_two_pin, direct_probe_one_pin};
        dp_sync_q <= dp_meta_q;
        dp_prev_q <= dp_sync_q;
    end

    // ****************************************************************
    // Position loop
    // ****************************************************************
    logic             loop_run;
    logic             tracking;
    logic [POS_W-1:0] sp_filt_q;
    logic [POS_W-1:0] sp_filt_d;
    logic [POS_W-1:0] integ_q;
    logic [POS_W-1:0] integ_d;
    logic [POS_W-1:0] follow_err;
    logic [GAIN_W-1:0] kp_eff;
    logic [POS_W-1:0] p_term;
    logic [POS_W-1:0] pi_sum;
    logic [POS_W-1:0] pi_limited;
    logic [POS_W-1:0] dt_line_q [DT_MAX];
    logic [POS_W-1:0] dt_out;
    logic [POS_W-1:0] pc_lag_q;
    logic [POS_W-1:0] pc_scaled;
    logic [POS_W-1:0] speed_d;

    assign loop_run   = loop_enable_a & loop_enable_b;
    assign tracking   = ~loop_enable_b & tracking_mode_sel;
    assign sp_filt_d  = tracking ? actual_position
                      : lag(sp_filt_q, position_setpoint, loop_cfg.setpoint_filter_tc);
    assign follow_err = sp_filt_q - actual_position;
    assign kp_eff     = GAIN_W'(scale({16'h0000, loop_cfg.prop_gain}, gain_adapt_in));
    assign p_term     = scale(follow_err, kp_eff);
    assign integ_d    = integ_q + scale(follow_err, loop_cfg.integral_gain);
    assign pi_sum     = p_term + integ_q;
    assign pi_limited = clamp(pi_sum, speed_limit_in);
    assign dt_out     = dt_line_q[loop_cfg.precontrol_deadtime];
    // Zero factor yields zero product, so pre-control vanishes entirely
    assign pc_scaled  = scale(pc_lag_q, loop_cfg.precontrol_factor);
    assign speed_d    = loop_run ? (pi_limited + pc_scaled) : POS_RESET;

    always_ff @(posedge clk) begin
        if (reset) begin
            sp_filt_q <= POS_RESET;
            integ_q   <= POS_RESET;
            pc_lag_q  <= POS_RESET;
            speed_setpoint <= POS_RESET;
            for (int i = 0; i < DT_MAX; i++) begin
                dt_line_q[i] <= POS_RESET;
            end
        end else if (cycle_en) begin
            sp_filt_q <= sp_filt_d;
            // Integrator held at zero while disabled to avoid windup on re-enable
            integ_q   <= loop_run ? integ_d : POS_RESET;
            dt_line_q[0] <= speed_precontrol_in;
            for (int i = 1; i < DT_MAX; i++) begin
                dt_line_q[i] <= dt_line_q[i-1];
            end
            pc_lag_q  <= lag(pc_lag_q, dt_out, loop_cfg.precontrol_lag);
            speed_setpoint <= speed_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            speed_limit_out <= POS_RESET;
        end else begin
            speed_limit_out <= loop_cfg.speed_limit_out;
        end
    end

    // ****************************************************************
    // Monitors
    // ****************************************************************
    logic             ss_start;
    logic             pos_start;
    logic             ss_start_q;
    logic             pos_start_q;
    logic [TIM_W-1:0] ss_tim_q;
    logic [TIM_W-1:0] pos_tim_q;
    logic             ss_expire;
    logic             pos_expire;
    logic [POS_W-1:0] err_abs;
    logic             ss_en;
    logic             pos_en;

    assign ss_en     = (mon_cfg.standstill_window != POS_RESET) & ~tracking;
    assign pos_en    = (mon_cfg.positioning_window != POS_RESET) & ~tracking;
    assign ss_start  = setpoint_stationary & ss_en;
    assign pos_start = setpoint_stationary & ~travel_cmd_active & pos_en;
    assign err_abs   = abs_val(follow_err);
    assign ss_expire = ss_start & ss_start_q & (ss_tim_q == 16'h0001);
    assign pos_expire = pos_start & pos_start_q & (pos_tim_q == 16'h0001);

    always_ff @(posedge clk) begin
        if (reset) begin
            ss_start_q  <= 1'b0;
            pos_start_q <= 1'b0;
            ss_tim_q    <= TIM_RESET;
            pos_tim_q   <= TIM_RESET;
            standstill_fault  <= 1'b0;
            positioning_fault <= 1'b0;
            follow_err_fault  <= 1'b0;
            follow_ok_bit     <= 1'b1;
            follow_err_value  <= POS_RESET;
        end else if (cycle_en) begin
            ss_start_q  <= ss_start;
            pos_start_q <= pos_start;
            // Reload on new start, stop when dropped; expiry reaches 0 once only
            if (ss_start & ~ss_start_q) begin
                ss_tim_q <= mon_cfg.standstill_time;
            end else if (ss_start & (ss_tim_q != TIM_RESET)) begin
                ss_tim_q <= ss_tim_q - 16'h0001;
            end
            if (pos_start & ~pos_start_q) begin
                pos_tim_q <= mon_cfg.positioning_time;
            end else if (pos_start & (pos_tim_q != TIM_RESET)) begin
                pos_tim_q <= pos_tim_q - 16'h0001;
            end
            if (ss_expire & (err_abs > mon_cfg.standstill_window)) begin
                standstill_fault <= 1'b1;
            end
            if (pos_expire & (err_abs > mon_cfg.positioning_window)) begin
                positioning_fault <= 1'b1;
            end
            follow_err_value <= follow_err;
            if (~tracking & (abs_val(follow_err_value) > mon_cfg.follow_err_tolerance)) begin
                follow_err_fault <= 1'b1;
                follow_ok_bit    <= 1'b0;
            end else begin
                follow_ok_bit    <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Cam comparators
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            cam_out_one <= 1'b0;
            cam_out_two <= 1'b0;
        end else if (cycle_en) begin
            cam_out_one <= $signed(actual_position) <= $signed(mon_cfg.cam_pos_one);
            cam_out_two <= $signed(actual_position) <= $signed(mon_cfg.cam_pos_two);
        end
    end

    // ****************************************************************
    // Reference search / probe handshake
    // ****************************************************************
    fn_state_t        fn_q;
    fn_state_t        fn_d;
    logic             ref_q;
    logic             probe_q;
    logic             both_req;
    logic             any_req;
    logic             start_ref;
    logic             start_probe;
    logic             sel_direct;
    logic             direct_edge;
    logic             direct_hit;
    logic             done_hit;
    logic             is_probe_q;
    logic [ECW_W-1:0] ecw_d;

    assign both_req    = ref_search_req & probe_meas_req;
    assign any_req     = ref_search_req | probe_meas_req;
    assign start_ref   = ref_search_req & ~ref_q & ~probe_meas_req;
    assign start_probe = probe_meas_req & ~probe_q & ~ref_search_req;
    assign sel_direct  = probe_select ? direct_probe_two_en : direct_probe_one_en;
    assign direct_edge = probe_select
                       ? (probe_edge_select ? (dp_prev_q[1] & ~dp_sync_q[1])
                                            : (~dp_prev_q[1] & dp_sync_q[1]))
                       : (probe_edge_select ? (dp_prev_q[0] & ~dp_sync_q[0])
                                            : (~dp_prev_q[0] & dp_sync_q[0]));
    assign direct_hit  = is_probe_q & sel_direct & direct_edge;
    assign done_hit    = enc_status.meas_present | direct_hit;

    always_comb begin
        fn_d  = fn_q;
        ecw_d = '0;
        case (fn_q)
            FN_IDLE: begin
                if (both_req) begin
                    fn_d = FN_BLOCK;
                end else if (start_ref | start_probe) begin
                    fn_d = FN_RUN;
                end
            end
            FN_RUN: begin
                if (both_req | enc_status.fault) begin
                    fn_d = FN_BLOCK;
                end else if (~any_req) begin
                    fn_d = FN_IDLE;
                end else if (done_hit) begin
                    fn_d = FN_DONE;
                end
            end
            FN_DONE: begin
                if (both_req) begin
                    fn_d = FN_BLOCK;
                end else if (~any_req) begin
                    fn_d = FN_IDLE;
                end
            end
            FN_BLOCK: begin
                if (~any_req) begin
                    fn_d = FN_IDLE;
                end
            end
            default: fn_d = FN_IDLE;
        endcase
        if (fn_d == FN_RUN) begin
            ecw_d[ECW_REF_BIT]   = ~is_probe_q & ~start_probe | start_ref;
            ecw_d[ECW_PROBE_BIT] = (is_probe_q & ~start_ref) | start_probe;
            ecw_d[ECW_SEL_BIT]   = probe_select;
            ecw_d[ECW_EDGE_BIT]  = probe_edge_select;
        end
        if (fn_q == FN_RUN && fn_d != FN_RUN && fn_d != FN_DONE) begin
            ecw_d[ECW_ABORT_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            fn_q       <= FN_IDLE;
            ref_q      <= 1'b0;
            probe_q    <= 1'b0;
            is_probe_q <= 1'b0;
            enc_ctrl_word      <= '0;
            func_active_bit    <= 1'b0;
            meas_valid_bit     <= 1'b0;
            captured_position  <= POS_RESET;
            func_interrupted   <= 1'b0;
            probe_conflict_msg <= 1'b0;
        end else begin
            fn_q    <= fn_d;
            ref_q   <= ref_search_req;
            probe_q <= probe_meas_req;
            if (start_probe | start_ref) begin
                is_probe_q <= start_probe;
            end
            enc_ctrl_word <= ecw_d;
            func_active_bit <= ((fn_d == FN_RUN) & enc_status.func_active)
                             | (fn_d == FN_DONE);
            meas_valid_bit  <= (fn_d == FN_DONE);
            if (fn_q == FN_RUN && fn_d == FN_DONE) begin
                captured_position <= direct_hit ? actual_position
                                                : enc_status.meas_value;
            end
            func_interrupted <= (fn_d == FN_BLOCK);
            probe_conflict_msg <= probe_meas_req &
                (probe_select ? probe_two_in_use : probe_one_in_use);
        end
    end

endmodule

// *** dv/pos_enc_model.sv ***
// Encoder interface model: answers the control word with status and a captured value
`timescale 1ns/1ps
module pos_enc_model
    import pos_loop_pkg::*;
#(
    parameter int DLY = 40                   // Capture presented DLY+1 clocks after the start
)(
    input  wire logic             clk,           // Clock
    input  wire logic             reset,         // Sync reset
    input  wire logic [ECW_W-1:0] enc_ctrl_word, // Control word from the block
    input  wire logic             enc_fault_cmd, // Bench orders a fault
    output enc_status_t           enc_status     // Status word to the block
);
    localparam logic [POS_W-1:0] MV = 32'h0000_1234;
    int n;
    wire go = (enc_ctrl_word[ECW_REF_BIT] | enc_ctrl_word[ECW_PROBE_BIT]) & ~enc_ctrl_word[ECW_ABORT_BIT];
    always_ff @(posedge clk) n <= (reset || !go) ? 0 : n + 1;
    // Not presenting: show the inverse so a stale latch cannot pass
    assign enc_status = '{fault: enc_fault_cmd & go, func_active: go && n > 0,
                          meas_present: go && n > DLY, meas_value: (go && n > DLY) ? MV : ~MV};
endmodule

// *** dv/position_loop_monitor_probe_properties.sv ***
// Checker: timing relations at the ports of the position loop block
`timescale 1ns/1ps
module position_loop_monitor_probe_properties
    import pos_loop_pkg::*;
(
    input wire logic clk, reset, cycle_en, loop_enable_a, loop_enable_b, tracking_mode_sel,
    input wire logic ref_search_req, probe_meas_req, func_interrupted, meas_valid_bit,
    input wire logic func_active_bit, cam_out_one, follow_err_fault, follow_ok_bit,
    input wire mon_cfg_t mon_cfg,
    input wire logic [POS_W-1:0] actual_position, speed_setpoint, captured_position,
    input wire logic [POS_W-1:0] follow_err_value,
    input wire logic [ECW_W-1:0] enc_ctrl_word
);
    wire cam_le = $signed(actual_position) <= $signed(mon_cfg.cam_pos_one);
    wire [POS_W-1:0] fe_abs = follow_err_value[POS_W-1] ? -follow_err_value : follow_err_value;
    wire mon_on = loop_enable_b || !tracking_mode_sel;
    wire any_req = ref_search_req || probe_meas_req;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_ref_start; $rose(ref_search_req) && !probe_meas_req && !func_interrupted; endsequence
    sequence s_run_drop; |enc_ctrl_word[ECW_PROBE_BIT:ECW_REF_BIT] && !any_req; endsequence
    property p_off; cycle_en && !(loop_enable_a && loop_enable_b) |=> speed_setpoint == '0; endproperty
    a_off: assert property (p_off) else $error("speed not zero while disabled");
    property p_cam; cycle_en |=> cam_out_one == $past(cam_le); endproperty
    a_cam: assert property (p_cam) else $error("cam output wrong");
    property p_start; s_ref_start |=> enc_ctrl_word[ECW_REF_BIT]; endproperty
    a_start: assert property (p_start) else $error("request not forwarded");
    property p_drop; s_run_drop |=> enc_ctrl_word[ECW_ABORT_BIT] && !func_active_bit; endproperty
    a_drop: assert property (p_drop) else $error("early drop not aborted");
    property p_both; ref_search_req && probe_meas_req |=> func_interrupted; endproperty
    a_both: assert property (p_both) else $error("no alarm on both requests");
    property p_hold; func_interrupted && any_req |=> func_interrupted; endproperty
    a_hold: assert property (p_hold) else $error("alarm released early");
    property p_keep;
        meas_valid_bit && any_req && !(ref_search_req && probe_meas_req)
            |=> meas_valid_bit && func_active_bit && $stable(captured_position);
    endproperty
    a_keep: assert property (p_keep) else $error("result not held");
    property p_follow;
        cycle_en && mon_on && fe_abs > mon_cfg.follow_err_tolerance |=> follow_err_fault && !follow_ok_bit;
    endproperty
    a_follow: assert property (p_follow) else $error("following error not flagged");
endmodule
bind position_loop_monitor_probe position_loop_monitor_probe_properties chk_inst (.*);

// *** dv/position_loop_monitor_probe_tb.sv ***
// Testbench: loop and cam table, then probe, alarm and monitor scenarios
`timescale 1ns/1ps
module position_loop_monitor_probe_tb;
    import pos_loop_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic clk = 0, reset = 1, cycle_en = 0, loop_enable_a = 0, loop_enable_b = 0;
    logic tracking_mode_sel = 0, setpoint_stationary = 0, travel_cmd_active = 0, ref_search_req = 0;
    logic probe_meas_req = 0, probe_select = 0, probe_edge_select = 0, direct_probe_one_pin = 0;
    logic direct_probe_one_en = 0, probe_one_in_use = 0, enc_fault_cmd = 0;
    logic [1:0] cnt = 2'h0;
    logic [POS_W-1:0] actual_position = 32'h0, speed_setpoint, speed_limit_out, follow_err_value;
    logic [POS_W-1:0] captured_position, speed_precontrol_in = 32'h10;
    logic [GAIN_W-1:0] gain_adapt_in = 16'h0100;
    logic follow_ok_bit, standstill_fault, positioning_fault, follow_err_fault, cam_out_one;
    logic cam_out_two, func_active_bit, meas_valid_bit, func_interrupted, probe_conflict_msg;
    logic [ECW_W-1:0] enc_ctrl_word;
    loop_cfg_t loop_cfg = '{prop_gain: 16'h0100, speed_limit_out: 32'h32, default: '0};
    mon_cfg_t mon_cfg = '{follow_err_tolerance: 32'h7FFF_FFFF, cam_pos_one: 32'h64, default: '0};
    enc_status_t enc_status;
    int errors = 0, checks_done = 0;
    wire [5:0] watch = {probe_conflict_msg, follow_err_fault, positioning_fault,
                        standstill_fault, func_interrupted, meas_valid_bit};
    typedef struct { logic [POS_W-1:0] a; logic e1, e2, cam, off; } row_t;
    row_t rows [4] = '{'{32'h63, 1'h1, 1'h1, 1'h1, 1'h0}, '{32'h64, 1'h1, 1'h0, 1'h1, 1'h1},
                       '{32'h65, 1'h0, 1'h1, 1'h0, 1'h1}, '{32'hFFFF_FFFB, 1'h0, 1'h0, 1'h1, 1'h1}};
    position_loop_monitor_probe position_loop_monitor_probe_inst (.*, .position_setpoint(32'h0),
        .speed_limit_in(speed_limit_out),
        .direct_probe_two_pin(1'h0), .direct_probe_two_en(1'h0), .probe_two_in_use(probe_one_in_use));
    pos_enc_model pos_enc_model_inst (.*);
    initial forever #12.5 clk = ~clk;
    // Loop cycle every fourth clock, a whole multiple of the clock
    always @(negedge clk) begin
        cnt <= cnt + 2'h1;
        cycle_en <= (cnt == 2'h3);
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [POS_W-1:0] s, input logic [POS_W-1:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("ERROR %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic results;
        $display("Checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Bounded wait for one watched flag; running out ends the run
    task automatic wt(input int b);
        for (int i = 0; i < 300; i++) begin
            if (watch[b] === 1'h1) return;
            @(negedge clk);
        end
        errors++;
        results();
    endtask
    task automatic clks(input int k);
        repeat (k) @(negedge clk);
    endtask
    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        clks(12);
        reset = 0;
        chk({follow_ok_bit, standstill_fault, follow_err_fault, func_active_bit, func_interrupted}, 5'h10);
        foreach (rows[i]) begin
            actual_position = rows[i].a;
            loop_enable_a = rows[i].e1;
            loop_enable_b = rows[i].e2;
            clks(9);
            chk(cam_out_one, rows[i].cam);
            chk(speed_setpoint == '0, rows[i].off);
        end
        {loop_enable_a, loop_enable_b, actual_position} = {2'h3, 32'h64};
        clks(9);
        chk(speed_setpoint, 32'hFFFF_FFCE);
        {gain_adapt_in, loop_cfg.precontrol_factor} = 32'h0040_0200;
        clks(9);
        chk(speed_setpoint, 32'h0000_0007);
        ref_search_req = 1;
        clks(3);
        chk({func_active_bit, enc_ctrl_word}, 6'h21);
        wt(0);
        clks(5);
        chk({meas_valid_bit, func_active_bit, captured_position[29:0]}, 32'hC000_1234);
        ref_search_req = 0;
        clks(2);
        chk(meas_valid_bit, 1'h0);
        {probe_select, probe_edge_select, probe_meas_req} = 3'h7;
        clks(3);
        chk(enc_ctrl_word[3:1], 3'h7);
        probe_meas_req = 0;
        clks(1);
        chk({enc_ctrl_word[ECW_ABORT_BIT], func_active_bit}, 2'h2);
        ref_search_req = 1;
        clks(3);
        probe_meas_req = 1;
        wt(1);
        ref_search_req = 0;
        clks(3);
        chk({func_interrupted, enc_ctrl_word[ECW_REF_BIT]}, 2'h2);
        probe_meas_req = 0;
        clks(2);
        chk(func_interrupted, 1'h0);
        ref_search_req = 1;
        clks(4);
        enc_fault_cmd = 1;
        wt(1);
        {enc_fault_cmd, ref_search_req, probe_select, probe_edge_select} = 4'h0;
        {direct_probe_one_en, probe_one_in_use, actual_position} = {2'h3, 32'h77};
        clks(2);
        probe_meas_req = 1;
        wt(5);
        clks(3);
        direct_probe_one_pin = 1;
        wt(0);
        chk(captured_position, 32'h77);
        {probe_meas_req, direct_probe_one_en, probe_one_in_use, direct_probe_one_pin} = 4'h0;
        mon_cfg = '{32'h1, 16'h3, 32'h1, 16'h3, 32'h1, 32'h64, 32'h0};
        {setpoint_stationary, actual_position} = {1'h1, 32'h63};
        wt(2);
        wt(3);
        wt(4);
        chk(follow_ok_bit, 1'h0);
        {reset, loop_enable_b, tracking_mode_sel} = 3'h5;
        clks(2);
        reset = 0;
        clks(40);
        chk({standstill_fault, positioning_fault, follow_err_fault}, 3'h0);
        {mon_cfg.standstill_window, mon_cfg.positioning_window} = 64'h0;
        {loop_enable_b, tracking_mode_sel} = 2'h2;
        clks(40);
        chk({standstill_fault, positioning_fault}, 2'h0);
        results();
    end
endmodule
